// file: adcc_ctrl.sv
// Converter control top: Avalon-MM register file, start control and interrupt.
`default_nettype none
`include "adcc_regs.svh"
module adcc_ctrl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Pins
    input  wire logic        comp_in,
    input  wire logic        hw_trigger,
    // Analog front end control
    output logic [2:0]       channel_sel,
    output logic             ref_gen_on,
    output logic             sample_hold,
    output logic [9:0]       dac_code,
    output logic             conv_busy,
    // Interrupt
    output logic             conv_end_irq
);

    adcc_pkg::adcc_ctrl_state_t s;
    adcc_pkg::adcc_ctrl_state_t next_s;

    logic [8:0] conv_len;
    logic [7:0] samp_len;
    logic [3:0] wr_delay;
    logic [3:0] trig_delay;
    logic [6:0] step_len;
    logic       prohibited;
    logic       sar_busy;
    logic       sar_done;
    logic [9:0] sar_result;
    logic       sar_start;
    logic [3:0] sar_delay;
    logic       sar_abort;
    logic       req;
    logic       wr_acc;
    logic       wr_mode;
    logic       wr_chan;
    logic       high_speed;
    logic       ref_settled;
    logic       trig_edge;
    logic [9:0] ref_need;

    // Address match, shared by the read mux and every write strobe.
    function automatic logic adcc_hit(input logic [4:0] addr, input logic [4:0] ofs);
        adcc_hit = (addr == ofs);
    endfunction : adcc_hit

    // Read mux; unmapped words read as zero.
    function automatic logic [31:0] adcc_rd(
        input logic [4:0]                  addr,
        input adcc_pkg::adcc_ctrl_state_t  st,
        input logic [4:0]                  stat
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        if (adcc_hit(addr, `ADCC_OFS_MODE))
        begin
            d[`ADCC_MODE_EN]   = st.conv_en;
            d[`ADCC_MODE_REF]  = st.ref_en;
            d[`ADCC_MODE_FR]   = st.ftime;
            d[`ADCC_MODE_HS]   = st.speed;
            d[`ADCC_MODE_TRIG] = st.trig_mode;
        end
        else if (adcc_hit(addr, `ADCC_OFS_CHAN))
        begin
            d[`ADCC_CHAN_SEL] = st.chan;
        end
        else if (adcc_hit(addr, `ADCC_OFS_RESULT))
        begin
            d[`ADCC_RES_VAL]     = st.result;
            d[`ADCC_RES_SUSPECT] = st.res_suspect;
            d[`ADCC_RES_VALID]   = st.res_valid;
        end
        else if (adcc_hit(addr, `ADCC_OFS_STATUS))
        begin
            d[4:0] = stat;
        end
        else if (adcc_hit(addr, `ADCC_OFS_IRQ_STAT))
        begin
            d[1:0] = st.irq_stat;
        end
        else if (adcc_hit(addr, `ADCC_OFS_IRQ_EN))
        begin
            d[1:0] = st.irq_en;
        end
        adcc_rd = d;
    endfunction : adcc_rd

    // Timing lookup for the current mode setting.
    adcc_timing u_timing (
        .speed      (s.speed),
        .ftime      (s.ftime),
        .conv_len   (conv_len),
        .samp_len   (samp_len),
        .wr_delay   (wr_delay),
        .trig_delay (trig_delay),
        .step_len   (step_len),
        .prohibited (prohibited)
    );

    // Approximation sequencer.
    adcc_sar u_sar (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .start       (sar_start),
        .start_delay (sar_delay),
        .abort       (sar_abort),
        .samp_len    (samp_len),
        .conv_len    (conv_len),
        .step_len    (step_len),
        .comp_in     (comp_in),
        .dac_code    (dac_code),
        .sample_hold (sample_hold),
        .busy        (sar_busy),
        .done        (sar_done),
        .result      (sar_result)
    );

    // Bus strobes: a request waits one cycle, then completes at the next edge.
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~s.ack;
    assign wr_acc          = avs_write & s.ack & avs_byteenable[0];
    assign wr_mode         = wr_acc & adcc_hit(avs_address, `ADCC_OFS_MODE);
    assign wr_chan         = wr_acc & adcc_hit(avs_address, `ADCC_OFS_CHAN);

    // Reference settling needs the longer wait in normal speed.
    assign high_speed  = (s.speed != `ADCC_SPEED_NORMAL);
    assign ref_need    = high_speed ? `ADCC_REF_HS_CYC : `ADCC_REF_NORM_CYC;
    assign ref_settled = s.ref_en & (s.ref_cnt >= ref_need);
    assign trig_edge   = s.trg_sync & ~s.trg_prev;

    // Start selection: software restart after a write, back-to-back repeat, or a trigger.
    always_comb
    begin
        sar_start = 1'b0;
        sar_delay = 4'h0;
        sar_abort = wr_mode | wr_chan | ~s.conv_en;
        if (s.restart && s.conv_en && !s.trig_mode && !prohibited)
        begin
            sar_start = 1'b1;
            sar_delay = wr_delay - 4'h1;
        end
        else if (sar_done && !sar_abort && !s.trig_mode && !prohibited)
        begin
            sar_start = 1'b1;
        end
        else if (trig_edge && !sar_abort && s.trig_mode && high_speed && !prohibited)
        begin
            // A trigger during a high-speed conversion throws it away and starts over.
            sar_start = 1'b1;
            sar_delay = trig_delay;
        end
    end

    // Register file, result capture and interrupt flags.
    always_comb
    begin
        next_s          = s;
        next_s.ack      = req & ~s.ack;
        next_s.restart  = wr_mode | wr_chan;
        next_s.trg_meta = hw_trigger;
        next_s.trg_sync = s.trg_meta;
        next_s.trg_prev = s.trg_sync;
        if (req && !s.ack)
        begin
            next_s.rdata = adcc_rd(avs_address, s,
                {s.trig_mode & ~sar_busy, prohibited, ref_settled, sample_hold, sar_busy});
        end
        if (!s.ref_en)
        begin
            next_s.ref_cnt = 10'h000;
        end
        else if (!ref_settled)
        begin
            next_s.ref_cnt = s.ref_cnt + 10'h001;
        end
        if (wr_mode)
        begin
            next_s.conv_en   = avs_writedata[`ADCC_MODE_EN];
            next_s.ref_en    = avs_writedata[`ADCC_MODE_REF];
            next_s.ftime     = avs_writedata[`ADCC_MODE_FR];
            next_s.speed     = avs_writedata[`ADCC_MODE_HS];
            next_s.trig_mode = avs_writedata[`ADCC_MODE_TRIG];
            // Enabling before the reference has settled taints the first result.
            if (avs_writedata[`ADCC_MODE_EN] && !s.conv_en)
            begin
                next_s.first_pending = ~ref_settled | ~avs_writedata[`ADCC_MODE_REF];
            end
        end
        if (wr_chan)
        begin
            next_s.chan = avs_writedata[`ADCC_CHAN_SEL];
        end
        if (wr_mode || wr_chan)
        begin
            next_s.res_valid = 1'b0;
        end
        if (wr_acc && adcc_hit(avs_address, `ADCC_OFS_IRQ_EN))
        begin
            next_s.irq_en = avs_writedata[1:0];
        end
        if (wr_acc && adcc_hit(avs_address, `ADCC_OFS_IRQ_CLR))
        begin
            // Only an explicit clear lowers the flags; channel writes never clear them.
            next_s.irq_stat = s.irq_stat & ~avs_writedata[1:0];
        end
        // A mode or channel write in the finishing cycle wins: no store and no flag.
        if (sar_done && !wr_mode && !wr_chan)
        begin
            next_s.result                   = sar_result;
            next_s.res_valid                = 1'b1;
            next_s.res_suspect              = s.first_pending;
            next_s.first_pending            = 1'b0;
            next_s.irq_stat[`ADCC_IRQ_CONV] = 1'b1;
        end
        if (s.restart && s.conv_en && prohibited)
        begin
            next_s.irq_stat[`ADCC_IRQ_BAD] = 1'b1;
        end
    end

    // State register; reset leaves the converter stopped and the reference off.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s           <= '0;
            s.conv_en   <= 1'(`ADCC_MODE_RST >> `ADCC_MODE_EN);
            s.chan      <= `ADCC_CHAN_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs.
    assign avs_readdata = s.rdata;
    assign channel_sel  = s.chan;
    assign ref_gen_on   = s.ref_en;
    assign conv_busy    = sar_busy;
    assign conv_end_irq = |(s.irq_stat & s.irq_en);

endmodule : adcc_ctrl
`default_nettype wire

// file: adcc_regs.svh
// Register map, field positions, reset values and timing constants of the converter control.
// Behaviour
// - Writing the channel register leaves the conversion-end flag exactly as it was.
// - A conversion whose finishing cycle meets a channel write stores no result and sets no conversion-end flag.
// - A first result started before the reference has settled is marked as outside rating.
// - Any mode or channel write leaves the result register marked not valid.
// - A start delay passes before sampling on a write or trigger start, none on a back-to-back repeat, and the sampling time follows the mode setting.
// - Normal speed codes give 288, 240, 192, 144, 120 and 96 cycle conversions, others barred.
// - Speed 01 gives 24 to 224 cycles over eight codes and speed 10 gives 72 to 18 cycles.
// - Sampling lasts the tabulated cycles of the setting, from 176 down to 6.
// - Write response takes 8 to 11 cycles and trigger response 4 to 7 cycles.
// - Each finished conversion stores its result and sets the conversion-end flag, unless a mode or channel write falls in its finishing cycle.
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_OFS_MODE     5'h00
`define ADCC_OFS_CHAN     5'h04
`define ADCC_OFS_RESULT   5'h08
`define ADCC_OFS_STATUS   5'h0c
`define ADCC_OFS_IRQ_STAT 5'h10
`define ADCC_OFS_IRQ_CLR  5'h14
`define ADCC_OFS_IRQ_EN   5'h18

`define ADCC_MODE_EN      0
`define ADCC_MODE_REF     1
`define ADCC_MODE_FR      4:2
`define ADCC_MODE_HS      6:5
`define ADCC_MODE_TRIG    7
`define ADCC_CHAN_SEL     2:0
`define ADCC_RES_VAL      9:0
`define ADCC_RES_SUSPECT  14
`define ADCC_RES_VALID    15
`define ADCC_IRQ_CONV     0
`define ADCC_IRQ_BAD      1

`define ADCC_MODE_RST     8'h00
`define ADCC_CHAN_RST     3'h0
`define ADCC_SPEED_NORMAL 2'h0
`define ADCC_SAR_MSB      4'h9
`define ADCC_SAR_FIRST    10'h200
`define ADCC_SAR_STEPS    7'h0a

`define ADCC_CLK_NS       20
`define ADCC_REF_HS_NS    1000
`define ADCC_REF_NORM_NS  14000
`define ADCC_REF_HS_CYC   10'((`ADCC_REF_HS_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_REF_NORM_CYC 10'((`ADCC_REF_NORM_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

// Rows: conversion, sampling, write response min, trigger response min, in cycles.
`define ADCC_T_00_000 {9'h120, 8'hb0, 4'hb, 4'h7}
`define ADCC_T_00_001 {9'h0f0, 8'hb0, 4'hb, 4'h7}
`define ADCC_T_00_010 {9'h0c0, 8'h84, 4'ha, 4'h6}
`define ADCC_T_00_100 {9'h090, 8'h58, 4'h9, 4'h5}
`define ADCC_T_00_101 {9'h078, 8'h58, 4'h9, 4'h5}
`define ADCC_T_00_110 {9'h060, 8'h30, 4'hb, 4'h7}
`define ADCC_T_01_000 {9'h060, 8'h30, 4'hb, 4'h7}
`define ADCC_T_01_001 {9'h048, 8'h24, 4'ha, 4'h6}
`define ADCC_T_01_010 {9'h030, 8'h18, 4'h9, 4'h5}
`define ADCC_T_01_011 {9'h018, 8'h0c, 4'h8, 4'h4}
`define ADCC_T_01_100 {9'h0e0, 8'hb0, 4'hb, 4'h7}
`define ADCC_T_01_101 {9'h0a8, 8'h84, 4'ha, 4'h6}
`define ADCC_T_01_110 {9'h070, 8'h58, 4'h9, 4'h5}
`define ADCC_T_01_111 {9'h038, 8'h2c, 4'h8, 4'h4}
`define ADCC_T_10_000 {9'h048, 8'h18, 4'hb, 4'h7}
`define ADCC_T_10_001 {9'h036, 8'h12, 4'ha, 4'h6}
`define ADCC_T_10_010 {9'h024, 8'h0c, 4'h9, 4'h5}
`define ADCC_T_10_011 {9'h012, 8'h06, 4'h8, 4'h4}
`define ADCC_T_NONE   {9'h000, 8'h00, 4'h0, 4'h0}

`endif

// file: adcc_pkg.sv
// Types shared by the converter control modules.
`default_nettype none
package adcc_pkg;

    // Converter sequencing phases.
    typedef enum logic [1:0]
    {
        ADCC_IDLE    = 2'b00,
        ADCC_DELAY   = 2'b01,
        ADCC_SAMPLE  = 2'b10,
        ADCC_CONVERT = 2'b11
    } adcc_phase_t;

    // One row of the timing table.
    typedef struct packed {
        logic [8:0] conv_len;
        logic [7:0] samp_len;
        logic [3:0] wr_delay;
        logic [3:0] trig_delay;
    } adcc_timing_t;

    // Whole state of the approximation sequencer.
    typedef struct packed {
        adcc_phase_t phase;
        logic [8:0]  cnt;
        logic [6:0]  step_cnt;
        logic [3:0]  bit_idx;
        logic [9:0]  code;
        logic [9:0]  result;
        logic        done;
        logic        cmp_meta;
        logic        cmp_sync;
    } adcc_sar_state_t;

    // Whole state of the control block and its register file.
    typedef struct packed {
        logic        conv_en;
        logic        ref_en;
        logic        trig_mode;
        logic [1:0]  speed;
        logic [2:0]  ftime;
        logic [2:0]  chan;
        logic [9:0]  result;
        logic        res_valid;
        logic        res_suspect;
        logic        first_pending;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_en;
        logic [9:0]  ref_cnt;
        logic        restart;
        logic        trg_meta;
        logic        trg_sync;
        logic        trg_prev;
        logic        ack;
        logic [31:0] rdata;
    } adcc_ctrl_state_t;

endpackage : adcc_pkg
`default_nettype wire

// file: adcc_timing.sv
// Timing table lookup from the speed and conversion-time fields.
`default_nettype none
`include "adcc_regs.svh"
module adcc_timing (
    // Mode fields
    input  wire logic [1:0] speed,
    input  wire logic [2:0] ftime,
    // Selected timing
    output logic [8:0]      conv_len,
    output logic [7:0]      samp_len,
    output logic [3:0]      wr_delay,
    output logic [3:0]      trig_delay,
    output logic [6:0]      step_len,
    output logic            prohibited
);

    adcc_pkg::adcc_timing_t row;

    // Unlisted codes return an all-zero row, which also flags them as barred.
    always_comb
    begin
        unique case ({speed, ftime})
            5'h00:   row = `ADCC_T_00_000;
            5'h01:   row = `ADCC_T_00_001;
            5'h02:   row = `ADCC_T_00_010;
            5'h04:   row = `ADCC_T_00_100;
            5'h05:   row = `ADCC_T_00_101;
            5'h06:   row = `ADCC_T_00_110;
            5'h08:   row = `ADCC_T_01_000;
            5'h09:   row = `ADCC_T_01_001;
            5'h0a:   row = `ADCC_T_01_010;
            5'h0b:   row = `ADCC_T_01_011;
            5'h0c:   row = `ADCC_T_01_100;
            5'h0d:   row = `ADCC_T_01_101;
            5'h0e:   row = `ADCC_T_01_110;
            5'h0f:   row = `ADCC_T_01_111;
            5'h10:   row = `ADCC_T_10_000;
            5'h11:   row = `ADCC_T_10_001;
            5'h12:   row = `ADCC_T_10_010;
            5'h13:   row = `ADCC_T_10_011;
            default: row = `ADCC_T_NONE;
        endcase
        conv_len   = row.conv_len;
        samp_len   = row.samp_len;
        wr_delay   = row.wr_delay;
        trig_delay = row.trig_delay;
        prohibited = (row.conv_len == 9'h000);
        // Each bit decision gets an equal slice of the hold phase; leftovers idle at the end.
        step_len   = 7'((row.conv_len - {1'b0, row.samp_len}) / 9'(`ADCC_SAR_STEPS));
    end

endmodule : adcc_timing
`default_nettype wire

// file: adcc_sar.sv
// Successive approximation sequencer: start delay, sampling and bit decisions.
`default_nettype none
`include "adcc_regs.svh"
module adcc_sar (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       start,
    input  wire logic [3:0] start_delay,
    input  wire logic       abort,
    input  wire logic [7:0] samp_len,
    input  wire logic [8:0] conv_len,
    input  wire logic [6:0] step_len,
    // Analog side
    input  wire logic       comp_in,
    output logic [9:0]      dac_code,
    output logic            sample_hold,
    // Status
    output logic            busy,
    output logic            done,
    output logic [9:0]      result
);

    adcc_pkg::adcc_sar_state_t s;
    adcc_pkg::adcc_sar_state_t next_s;

    // One down-counter walks all phases, lengths taken from the live setting.
    always_comb
    begin
        next_s          = s;
        next_s.done     = 1'b0;
        next_s.cmp_meta = comp_in;
        next_s.cmp_sync = s.cmp_meta;
        if (start)
        begin
            next_s.code = 10'h000;
            if (start_delay == 4'h0)
            begin
                next_s.phase = adcc_pkg::ADCC_SAMPLE;
                next_s.cnt   = 9'({1'b0, samp_len} - 9'h001);
            end
            else
            begin
                next_s.phase = adcc_pkg::ADCC_DELAY;
                next_s.cnt   = 9'({5'h00, start_delay} - 9'h001);
            end
        end
        else if (abort)
        begin
            next_s.phase = adcc_pkg::ADCC_IDLE;
        end
        else
        begin
            unique case (s.phase)
                adcc_pkg::ADCC_IDLE:
                begin
                    next_s.cnt = 9'h000;
                end
                adcc_pkg::ADCC_DELAY:
                begin
                    next_s.cnt = s.cnt - 9'h001;
                    if (s.cnt == 9'h000)
                    begin
                        next_s.phase = adcc_pkg::ADCC_SAMPLE;
                        next_s.cnt   = 9'({1'b0, samp_len} - 9'h001);
                    end
                end
                adcc_pkg::ADCC_SAMPLE:
                begin
                    next_s.cnt = s.cnt - 9'h001;
                    if (s.cnt == 9'h000)
                    begin
                        next_s.phase    = adcc_pkg::ADCC_CONVERT;
                        next_s.cnt      = 9'(conv_len - {1'b0, samp_len} - 9'h001);
                        next_s.step_cnt = step_len - 7'h01;
                        next_s.bit_idx  = `ADCC_SAR_MSB;
                        next_s.code     = `ADCC_SAR_FIRST;
                    end
                end
                adcc_pkg::ADCC_CONVERT:
                begin
                    next_s.cnt      = s.cnt - 9'h001;
                    next_s.step_cnt = s.step_cnt - 7'h01;
                    if (s.step_cnt == 7'h00 && s.bit_idx <= `ADCC_SAR_MSB)
                    begin
                        // Keep the trial bit only while the input is above the trial level.
                        next_s.code[s.bit_idx] = s.cmp_sync;
                        if (s.bit_idx != 4'h0)
                        begin
                            next_s.code[s.bit_idx - 4'h1] = 1'b1;
                        end
                        next_s.bit_idx  = s.bit_idx - 4'h1;
                        next_s.step_cnt = step_len - 7'h01;
                    end
                    if (s.cnt == 9'h000)
                    begin
                        next_s.phase  = adcc_pkg::ADCC_IDLE;
                        next_s.done   = 1'b1;
                        next_s.result = next_s.code;
                    end
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign dac_code    = s.code;
    assign result      = s.result;
    assign done        = s.done;
    assign busy        = (s.phase != adcc_pkg::ADCC_IDLE);
    assign sample_hold = (s.phase == adcc_pkg::ADCC_SAMPLE);

endmodule : adcc_sar
`default_nettype wire

// file: adcc_ctrl_props.sv
// Port checker for the converter control top.
`default_nettype none
`include "adcc_regs.svh"
module adcc_ctrl_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    // Converter outputs
    input wire logic [2:0]  channel_sel,
    input wire logic        ref_gen_on,
    input wire logic        sample_hold,
    input wire logic        conv_busy,
    input wire logic        conv_end_irq
);
    logic       wr_ok;
    logic       mode_wr;
    logic [7:0] mode_q;
    logic [7:0] samp_q;

    // A write lands only at the edge where waitrequest is low.
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign mode_wr = wr_ok && avs_address == `ADCC_OFS_MODE;

    // Mode byte and length of the running sampling phase, kept to judge the table.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q <= 8'h00;
            samp_q <= 8'h00;
        end
        else
        begin
            mode_q <= mode_wr ? avs_writedata[7:0] : mode_q;
            samp_q <= sample_hold ? samp_q + 8'h01 : 8'h00;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Second wait cycle seen.");
    property p_busy;
        sample_hold |-> conv_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("Sampling while not busy.");
    property p_chan;
        wr_ok && avs_address == `ADCC_OFS_CHAN |=> channel_sel == $past(avs_writedata[2:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("Channel not taken.");
    property p_ref;
        mode_wr |=> ref_gen_on == $past(avs_writedata[1]);
    endproperty
    a_ref: assert property (p_ref) else $error("Reference enable not taken.");
    property p_irq_hold;
        wr_ok && avs_address == `ADCC_OFS_CHAN && conv_end_irq |=> conv_end_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("Channel write dropped flag.");
    property p_abort;
        mode_wr && !avs_writedata[0] |=> !conv_busy;
    endproperty
    a_abort: assert property (p_abort) else $error("Busy after disable.");
    property p_start;
        mode_wr && avs_writedata[7:0] == 8'h03 |=> !sample_hold[*8] ##[1:5] sample_hold;
    endproperty
    a_start: assert property (p_start) else $error("Start delay out of range.");
    property p_samp;
        $fell(sample_hold) && !$past(wr_ok) && mode_q == 8'h03 |-> samp_q == 8'd176;
    endproperty
    a_samp: assert property (p_samp) else $error("Sampling length wrong.");

    // Main scenarios reached.
    c_samp: cover property ($fell(sample_hold));
    c_irq: cover property ($rose(conv_end_irq));
    c_chan: cover property (wr_ok && avs_address == `ADCC_OFS_CHAN && conv_end_irq);
endmodule : adcc_ctrl_props

bind adcc_ctrl adcc_ctrl_props i_props (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .channel_sel, .ref_gen_on,
    .sample_hold, .conv_busy, .conv_end_irq);
`default_nettype wire

// file: test_adc_conversion_timing_control.sv
// Self-checking bench for the converter control block.
`default_nettype none
`include "adcc_regs.svh"
module test_adc_conversion_timing_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  channel_sel;
    logic        ref_gen_on;
    logic        sample_hold;
    logic [9:0]  dac_code;
    logic        conv_busy;
    logic        conv_end_irq;
    logic        hw_trigger = 1'b0;
    logic [31:0] q;
    int          err_total = 0;
    int          checks = 0;
    int          n;
    // Rows: mode byte with enable and reference on, sampling cycles, conversion cycles.
    logic [7:0]  md[18] = '{8'h03, 8'h07, 8'h0b, 8'h13, 8'h17, 8'h1b, 8'h23, 8'h27, 8'h2b,
                            8'h2f, 8'h33, 8'h37, 8'h3b, 8'h3f, 8'h43, 8'h47, 8'h4b, 8'h4f};
    int          sp[18] = '{176, 176, 132, 88, 88, 48, 48, 36, 24, 12, 176, 132, 88, 44,
                            24, 18, 12, 6};
    int          cv[18] = '{288, 240, 192, 144, 120, 96, 96, 72, 48, 24, 224, 168, 112, 56,
                            72, 54, 36, 18};

    // Comparator held high, so every trial bit is kept.
    adcc_ctrl i_dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .comp_in(1'b1),
        .hw_trigger, .channel_sel, .ref_gen_on, .sample_hold, .dac_code, .conv_busy,
        .conv_end_irq);

    always #10 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // A wait that used up its bound ends the run as a failure.
    task automatic guard(input int cnt);
        if (cnt >= 600)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : guard

    // One transfer; the request stands until waitrequest is seen low, then is released.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && k < 600)
        begin
            @(posedge clk);
            k++;
        end
        guard(k);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    // Time sampling from its first cycle, then the flag that follows the conversion end.
    task automatic measure(input int sexp, input int cexp);
        int s;
        n = 0;
        s = 0;
        while (sample_hold !== 1'b1 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        guard(n);
        while (sample_hold === 1'b1 && s < 600)
        begin
            @(negedge clk);
            s++;
        end
        chk(s, sexp);
        while (conv_end_irq !== 1'b1 && s < 600)
        begin
            @(negedge clk);
            s++;
        end
        guard(s);
        chk(s, cexp + 1);
        @(posedge clk);
    endtask : measure

    // Reset, the timing table, then the awkward cases.
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, `ADCC_OFS_MODE, 32'h0);
        chk(q, 32'h0);
        chk(32'({dac_code, conv_end_irq, ref_gen_on, channel_sel}), 32'h0);
        bus(1'b1, `ADCC_OFS_IRQ_EN, 32'h1);
        for (int i = 0; i < 18; i++)
        begin
            bus(1'b1, `ADCC_OFS_MODE, {24'h0, md[i]});
            bus(1'b1, `ADCC_OFS_IRQ_CLR, 32'h3);
            measure(sp[i], cv[i]);
            bus(1'b0, `ADCC_OFS_RESULT, 32'h0);
            chk(q & 32'h83ff, 32'h83ff);
            if (i == 0)
                chk(32'(q[14]), 32'h1);
        end
        // Channel change keeps the set flag but voids the stored result.
        bus(1'b1, `ADCC_OFS_CHAN, 32'h5);
        chk(32'({conv_end_irq, channel_sel}), 32'hd);
        bus(1'b0, `ADCC_OFS_RESULT, 32'h0);
        chk(32'(q[15]), 32'h0);
        bus(1'b1, `ADCC_OFS_MODE, 32'h0);
        bus(1'b1, `ADCC_OFS_IRQ_CLR, 32'h3);
        bus(1'b0, `ADCC_OFS_IRQ_STAT, 32'h0);
        chk({q[30:0], conv_busy}, 32'h0);
        // Barred setting: no start, masked then unmasked request.
        bus(1'b1, `ADCC_OFS_MODE, 32'h0f);
        bus(1'b0, `ADCC_OFS_IRQ_STAT, 32'h0);
        chk(32'({q[1:0], conv_busy, conv_end_irq}), 32'h8);
        bus(1'b1, `ADCC_OFS_IRQ_EN, 32'h3);
        chk(32'(conv_end_irq), 32'h1);
        bus(1'b1, `ADCC_OFS_MODE, 32'h0);
        bus(1'b1, `ADCC_OFS_IRQ_CLR, 32'h3);
        chk(32'(conv_end_irq), 32'h0);
        // Trigger mode at high speed.
        bus(1'b1, `ADCC_OFS_MODE, 32'ha3);
        hw_trigger <= 1'b1;
        measure(48, 96);
        bus(1'b0, 5'h1c, 32'h0);
        chk(q, 32'h0);
        report_and_stop();
    end
endmodule : test_adc_conversion_timing_control
`default_nettype wire
